// [src/wdt_consts.svh]
// Register map, field positions, reset values and codes of the watchdog block
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
// Register offsets
`define WDT_A_CTRL    4'h0
`define WDT_A_RELOAD  4'h1
`define WDT_A_FEED1   4'h2
`define WDT_A_FEED2   4'h3
`define WDT_A_IEN     4'h4
`define WDT_A_IPRI    4'h5
`define WDT_A_PWR     4'h6
`define WDT_A_ISTAT   4'h7
`define WDT_A_IMASK   4'h8
// Control register fields
`define WDT_CTL_MODE  0
`define WDT_CTL_FLAG  1
`define WDT_CTL_RUN   2
`define WDT_CTL_TAP   7:5
// Enable and priority fields
`define WDT_IEN_GLOB  7
`define WDT_IEN_WD    6
`define WDT_IPRI_WD   6
// Power control fields
`define WDT_PWR_IDLE  0
`define WDT_PWR_PD    1
`define WDT_PWR_GF    3:2
`define WDT_PWR_HI    7:6
// Status event bits
`define WDT_EV_UFLOW  0
`define WDT_EV_FEEDER 1
`define WDT_EV_PDBLK  2
// Reset values and codes
`define WDT_RELOAD_RST 8'hff
`define WDT_TAP_RST    3'h7
`define WDT_FEED1_KEY  8'ha5
`define WDT_FEED2_KEY  8'h5a
`define WDT_TAP_BASE   13'h0040
`define WDT_VEC_BASE   8'h03
`define WDT_VEC_STEP   8'h08
`define WDT_VEC_WD     8'h33
`endif

// [src/wdt_pkg.sv]
// Types shared by the watchdog block
package wdt_pkg;
  typedef enum logic [1:0] {
    WDT_FEED_IDLE  = 2'b00,
    WDT_FEED_ARMED = 2'b01
  } wdt_feed_t;
  typedef enum logic [1:0] {
    WDT_PWR_RUN  = 2'b00,
    WDT_PWR_IDLE = 2'b01,
    WDT_PWR_DOWN = 2'b11
  } wdt_pwr_t;
endpackage : wdt_pkg

// [src/wdt_prescaler.sv]
// Divide-by-twelve stage and tapped binary prescaler
`timescale 1ns/100ps
`include "wdt_consts.svh"
module wdt_prescaler
  import wdt_pkg::*;
#(
  parameter int STAGES = 13,
  parameter int DIV    = 12
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // Control
  input  wire logic              clear,
  input  wire logic [2:0]        tap,
  // Results
  output logic                   tick,
  output logic [STAGES-1:0]      stage_count
);
  logic [3:0]        div_cnt;
  logic              div_wrap;
  logic [STAGES-1:0] tap_mask;

  // Tap underflow: all stages below the tap wrap together
  assign div_wrap = (div_cnt == 4'(DIV - 1));
  assign tap_mask = STAGES'((`WDT_TAP_BASE << tap) - 13'h0001);
  assign tick     = div_wrap && ((stage_count & tap_mask) == tap_mask);

  // Divider and stage counter, both cleared on reload
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || clear)
    begin
      div_cnt     <= 4'h0;
      stage_count <= '0;
    end
    else
    begin
      div_cnt     <= div_wrap ? 4'h0 : 4'(div_cnt + 4'h1);
      stage_count <= div_wrap ? STAGES'(stage_count + 1'b1) : stage_count;
    end
  end
endmodule : wdt_prescaler

// [src/wdt_power_ctrl.sv]
// Idle and power-down sequencing with watchdog inhibit
`timescale 1ns/100ps
`include "wdt_consts.svh"
module wdt_power_ctrl
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic  clk_sys,
  input  wire logic  resetn,
  // Requests
  input  wire logic  power_control_register_wr,
  input  wire logic  power_down_request,
  input  wire logic  idle_request,
  input  wire logic  pd_inhibit,
  input  wire logic  wake,
  // State
  output wdt_pwr_t   pwr_state,
  output logic       pd_blocked
);
  wdt_pwr_t next_pwr_state;
  logic     pd_go;
  logic     idle_go;

  // Power-down wins over idle and is refused while inhibited
  assign pd_go      = power_control_register_wr && power_down_request && !pd_inhibit;
  assign idle_go    = power_control_register_wr && idle_request && !power_down_request;
  assign pd_blocked = power_control_register_wr && power_down_request && pd_inhibit;

  // Next power state
  always_comb
  begin
    next_pwr_state = pwr_state;
    unique case (pwr_state)
      WDT_PWR_RUN:
      begin
        if (pd_go)
          next_pwr_state = WDT_PWR_DOWN;
        else if (idle_go)
          next_pwr_state = WDT_PWR_IDLE;
      end
      WDT_PWR_IDLE,
      WDT_PWR_DOWN:
      begin
        if (wake)
          next_pwr_state = WDT_PWR_RUN;
      end
      default: next_pwr_state = WDT_PWR_RUN;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      pwr_state <= WDT_PWR_RUN;
    else
      pwr_state <= next_pwr_state;
  end
endmodule : wdt_power_ctrl

// [src/wdt_top.sv]
// Watchdog timer with interrupt hooks, power control and register port
`timescale 1ns/100ps
`include "wdt_consts.svh"
module wdt_top
  import wdt_pkg::*;
#(
  parameter int STAGES = 13,
  parameter int DIV    = 12,
  parameter int NSRC   = 6
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  // Register port
  input  wire logic [3:0]      addr,
  input  wire logic [7:0]      wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output logic      [7:0]      rdata,
  // Interrupt hooks from and to the core
  input  wire logic [NSRC-1:0] other_irq_req,
  input  wire logic            wd_irq_ack,
  output logic                 irq_pending,
  output logic                 irq_level_high,
  output logic      [7:0]      irq_vector,
  // Power and reset control
  input  wire logic            wake,
  output logic                 idle_mode,
  output logic                 power_down,
  output logic                 sys_reset_req,
  // Event interrupt
  output logic                 irq_out
);
  // Register state
  logic [2:0]      tap;
  logic            timer_run_control;
  logic            reset_mode_select;
  logic            mode_clear_pend;
  logic            underflow_flag;
  logic [7:0]      reload_value;
  logic [7:0]      count;
  logic [7:0]      irq_enable_register;
  logic [6:0]      irq_priority_register;
  logic [3:0]      pwr_keep;
  logic [2:0]      ev_status;
  logic [2:0]      ev_mask;
  wdt_feed_t       feed_st;
  wdt_feed_t       next_feed_st;
  wdt_pwr_t        pwr_state;
  logic            pd_blocked;
  logic            tick;
  logic [STAGES-1:0] stage_count;

  // Address decode
  logic wr_ctrl, wr_reload, wr_feed1, wr_feed2;
  logic wr_ien, wr_ipri, wr_pwr, wr_istat, wr_imask;
  assign wr_ctrl   = wr && (addr == `WDT_A_CTRL);
  assign wr_reload = wr && (addr == `WDT_A_RELOAD);
  assign wr_feed1  = wr && (addr == `WDT_A_FEED1);
  assign wr_feed2  = wr && (addr == `WDT_A_FEED2);
  assign wr_ien    = wr && (addr == `WDT_A_IEN);
  assign wr_ipri   = wr && (addr == `WDT_A_IPRI);
  assign wr_pwr    = wr && (addr == `WDT_A_PWR);
  assign wr_istat  = wr && (addr == `WDT_A_ISTAT);
  assign wr_imask  = wr && (addr == `WDT_A_IMASK);

  // Feed sequence: key one, then key two on the very next write
  logic feed_ok, feed_bad, key1_ok;
  assign key1_ok  = wr_feed1 && (wdata == `WDT_FEED1_KEY);
  assign feed_ok  = wr_feed2 && (wdata == `WDT_FEED2_KEY) && (feed_st == WDT_FEED_ARMED);
  assign feed_bad = wr && !feed_ok && ((feed_st == WDT_FEED_ARMED) ||
                    wr_feed2 || (wr_feed1 && !key1_ok));
  assign next_feed_st = !wr ? feed_st :
                        (key1_ok && feed_st == WDT_FEED_IDLE) ? WDT_FEED_ARMED : WDT_FEED_IDLE;

  // Counting and underflow
  logic active, dec_tick, underflow, reload_now;
  assign active     = reset_mode_select || timer_run_control;
  assign dec_tick   = tick && active;
  assign underflow  = dec_tick && (count == 8'h00);
  assign reload_now = underflow || feed_ok;

  // Tapped prescaler, cleared on every reload
  wdt_prescaler #(
    .STAGES (STAGES),
    .DIV    (DIV)
  ) u_presc (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .clear       (reload_now),
    .tap         (tap),
    .tick        (tick),
    .stage_count (stage_count)
  );

  // Idle and power-down control
  wdt_power_ctrl u_pwr (
    .clk_sys            (clk_sys),
    .resetn             (resetn),
    .power_control_register_wr            (wr_pwr),
    .power_down_request (wdata[`WDT_PWR_PD]),
    .idle_request       (wdata[`WDT_PWR_IDLE]),
    .pd_inhibit         (reset_mode_select),
    .wake               (wake),
    .pwr_state          (pwr_state),
    .pd_blocked         (pd_blocked)
  );
  assign idle_mode  = (pwr_state == WDT_PWR_IDLE);
  assign power_down = (pwr_state == WDT_PWR_DOWN);

  // Main counter with autoload
  logic [7:0] next_count;
  assign next_count = reload_now ? reload_value :
                      dec_tick   ? 8'(count - 8'h01) : count;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      count <= `WDT_RELOAD_RST;
    else
      count <= next_count;
  end

  // Feed tracker
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      feed_st <= WDT_FEED_IDLE;
    else
      feed_st <= next_feed_st;
  end

  // Control fields; mode clears only after a zero write and a feed
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      tap               <= `WDT_TAP_RST;
      timer_run_control <= 1'b0;
      reset_mode_select <= 1'b0;
      mode_clear_pend   <= 1'b0;
      reload_value      <= `WDT_RELOAD_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        tap               <= wdata[`WDT_CTL_TAP];
        timer_run_control <= wdata[`WDT_CTL_RUN];
      end
      if (wr_ctrl && wdata[`WDT_CTL_MODE])
        reset_mode_select <= 1'b1;
      else if (feed_ok && mode_clear_pend)
        reset_mode_select <= 1'b0;
      if (wr_ctrl)
        mode_clear_pend <= !wdata[`WDT_CTL_MODE] && reset_mode_select;
      else if (feed_ok)
        mode_clear_pend <= 1'b0;
      if (wr_reload)
        reload_value <= wdata;
    end
  end

  // Timeout flag: set beats software or acknowledge clear
  logic flag_clr;
  assign flag_clr = (wr_ctrl && !wdata[`WDT_CTL_FLAG]) || (wd_irq_ack && !reset_mode_select);
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      underflow_flag <= 1'b0;
    else if (underflow)
      underflow_flag <= 1'b1;
    else if (flag_clr)
      underflow_flag <= 1'b0;
  end

  // System reset request from watchdog underflow or broken feed
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      sys_reset_req <= 1'b0;
    else
      sys_reset_req <= (underflow && reset_mode_select) || feed_bad;
  end

  // Enable, priority and kept power bits
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      irq_enable_register   <= 8'h00;
      irq_priority_register <= 7'h00;
      pwr_keep              <= 4'h0;
    end
    else
    begin
      if (wr_ien)
        irq_enable_register <= wdata;
      if (wr_ipri)
        irq_priority_register <= wdata[6:0];
      if (wr_pwr)
        pwr_keep <= {wdata[`WDT_PWR_HI], wdata[`WDT_PWR_GF]};
    end
  end

  // Request arbitration: two levels, fixed polling order
  logic [NSRC:0] src_req, src_en, lvl_hi, lvl_lo;
  logic          wd_irq_req;
  assign wd_irq_req = underflow_flag && !reset_mode_select;
  assign src_req    = {wd_irq_req, other_irq_req};
  assign src_en     = src_req & irq_enable_register[NSRC:0]
                      & {(NSRC+1){irq_enable_register[`WDT_IEN_GLOB]}};
  assign lvl_hi     = src_en & irq_priority_register[NSRC:0];
  assign lvl_lo     = src_en & ~irq_priority_register[NSRC:0];

  // Lowest index wins; the watchdog sits at the top index
  logic [7:0] next_vector;
  logic       next_high;
  always_comb
  begin
    next_vector = 8'h00;
    next_high   = |lvl_hi;
    for (int i = NSRC; i >= 0; i--)
    begin
      if (next_high ? lvl_hi[i] : lvl_lo[i])
        next_vector = 8'(`WDT_VEC_BASE + 8'(i) * `WDT_VEC_STEP);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      irq_pending    <= 1'b0;
      irq_level_high <= 1'b0;
      irq_vector     <= 8'h00;
    end
    else
    begin
      irq_pending    <= |src_en;
      irq_level_high <= next_high;
      irq_vector     <= next_vector;
    end
  end

  // Event status: hardware set wins over write-one clear
  logic [2:0] ev_set;
  assign ev_set[`WDT_EV_UFLOW]  = underflow;
  assign ev_set[`WDT_EV_FEEDER] = feed_bad;
  assign ev_set[`WDT_EV_PDBLK]  = pd_blocked;
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      ev_status <= 3'h0;
      ev_mask   <= 3'h0;
    end
    else
    begin
      ev_status <= ev_set | (ev_status & ~(wr_istat ? wdata[2:0] : 3'h0));
      if (wr_imask)
        ev_mask <= wdata[2:0];
    end
  end
  assign irq_out = |(ev_status & ev_mask);

  // Read mux, data returned one cycle after the strobe
  logic [7:0] rd_mux;
  assign rd_mux = (addr == `WDT_A_CTRL)   ? {tap, 2'b00, timer_run_control,
                                             underflow_flag, reset_mode_select} :
                  (addr == `WDT_A_RELOAD) ? reload_value :
                  (addr == `WDT_A_IEN)    ? irq_enable_register :
                  (addr == `WDT_A_IPRI)   ? {1'b0, irq_priority_register} :
                  (addr == `WDT_A_PWR)    ? {pwr_keep[3:2], 2'b00, pwr_keep[1:0],
                                             power_down, idle_mode} :
                  (addr == `WDT_A_ISTAT)  ? {5'h00, ev_status} :
                  (addr == `WDT_A_IMASK)  ? {5'h00, ev_mask} : 8'h00;
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else
      rdata <= rd ? rd_mux : 8'h00;
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  count_dec_a: assert property (dec_tick && count != 8'h00 && !feed_ok |=> count == $past(count) - 8'h01)
    else $error("counter did not decrement on tick");
  count_hold_a: assert property (!dec_tick && !feed_ok |=> count == $past(count))
    else $error("counter moved without tick");
  uflow_reload_a: assert property (underflow |=> count == $past(reload_value) && ev_status[0])
    else $error("underflow did not reload");
  presc_clear_a: assert property (reload_now |=> stage_count == '0)
    else $error("prescaler not cleared on reload");
  tick_tap_a: assert property (tick |-> stage_count[4:0] == 5'h1f && stage_count[5 + tap -: 1] == 1'b1)
    else $error("tick off its tap");
  wd_noirq_a: assert property (reset_mode_select |-> !wd_irq_req)
    else $error("watchdog mode raised interrupt");
  irq_gate_a: assert property (irq_pending |-> $past(irq_enable_register[7]))
    else $error("interrupt without global enable");
  pd_inhibit_a: assert property (wr_pwr && wdata[1] && reset_mode_select && pwr_state == WDT_PWR_RUN
                                 |=> pwr_state != WDT_PWR_DOWN)
    else $error("power-down entered in watchdog mode");
  pd_first_a: assert property (wr_pwr && wdata[1:0] == 2'b11 && !reset_mode_select && pwr_state == WDT_PWR_RUN
                               |=> power_down && !idle_mode)
    else $error("idle taken over power-down");
  wd_reset_a: assert property (underflow && reset_mode_select |=> sys_reset_req)
    else $error("watchdog underflow without reset");
  timer_mode_a: assert property (underflow && !reset_mode_select && !feed_bad
                                 |=> !sys_reset_req && underflow_flag)
    else $error("timer underflow misbehaved");
  feed_load_a: assert property (feed_ok |=> count == $past(reload_value) ##1 !sys_reset_req)
    else $error("feed did not reload");
  bad_feed_a: assert property (feed_bad |=> sys_reset_req)
    else $error("broken feed without reset");

  timer_uflow_c: cover property (underflow && !reset_mode_select);
  wd_reset_c: cover property (underflow && reset_mode_select);
  feed_c: cover property (feed_ok);
  pd_block_c: cover property (pd_blocked);
endmodule : wdt_top

// [verification/wdt_core_model.sv]
// Behavioural core: watchdog vectoring and wake-up from sleep
`timescale 1ns/100ps
`include "wdt_consts.svh"
module wdt_core_model
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Bench control
  input  wire logic       serve,
  input  wire logic       slow,
  // Block outputs
  input  wire logic       irq_pending,
  input  wire logic [7:0] irq_vector,
  input  wire logic       idle_mode,
  input  wire logic       power_down,
  // Answers to the block
  output logic            wd_irq_ack,
  output logic            wake
);
  logic [2:0] ack_wait;
  logic [3:0] nap;
  logic       in_isr;
  wire        wd_req = irq_pending && (irq_vector == `WDT_VEC_WD);
  wire        asleep = idle_mode || power_down;

  // Enters the watchdog routine after a short or long delay
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      wd_irq_ack <= 1'b0;
      ack_wait   <= 3'h0;
      in_isr     <= 1'b0;
    end
    else
    begin
      wd_irq_ack <= 1'b0;
      if (in_isr)
        in_isr <= wd_req;  // Stay in the routine until the request drops
      else if (serve && wd_req)
      begin
        if (ack_wait == (slow ? 3'h4 : 3'h0))
        begin
          wd_irq_ack <= 1'b1;
          in_isr     <= 1'b1;
          ack_wait   <= 3'h0;
        end
        else
          ack_wait <= ack_wait + 3'h1;
      end
      else
        ack_wait <= 3'h0;
    end
  end

  // An outside event wakes the core a few cycles after it sleeps
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || !asleep)
    begin
      nap  <= 4'h0;
      wake <= 1'b0;
    end
    else if (nap == 4'h6)
      wake <= 1'b1;
    else
      nap <= nap + 4'h1;
  end
endmodule : wdt_core_model

// [verification/wdt_top_tb.sv]
// Self-checking bench for the watchdog block
`timescale 1ns/100ps
`include "wdt_consts.svh"
module wdt_top_tb;
  localparam int PER0 = 12 * 64;
  logic       clk_sys       = 1'b0;
  logic       resetn        = 1'b0;
  logic [3:0] addr          = 4'h0;
  logic [7:0] wdata         = 8'h00;
  logic       wr            = 1'b0;
  logic       rd            = 1'b0;
  logic [5:0] other_irq_req = 6'h00;
  logic       serve         = 1'b0;
  logic       slow          = 1'b0;
  logic [7:0] rdata;
  logic [7:0] irq_vector;
  logic       wd_irq_ack, irq_pending, irq_level_high, wake;
  logic       idle_mode, power_down, sys_reset_req, irq_out;
  int         fail_count = 0;
  int         n_compared = 0;
  int         seed       = 57;

  always #25 clk_sys = ~clk_sys;

  wdt_top #(.STAGES(13), .DIV(12), .NSRC(6)) i_wdt_top (
    .clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .other_irq_req(other_irq_req), .wd_irq_ack(wd_irq_ack), .irq_pending(irq_pending),
    .irq_level_high(irq_level_high), .irq_vector(irq_vector), .wake(wake), .idle_mode(idle_mode),
    .power_down(power_down), .sys_reset_req(sys_reset_req), .irq_out(irq_out));

  wdt_core_model i_wdt_core_model (
    .clk_sys(clk_sys), .resetn(resetn), .serve(serve), .slow(slow), .irq_pending(irq_pending),
    .irq_vector(irq_vector), .idle_mode(idle_mode), .power_down(power_down), .wd_irq_ack(wd_irq_ack),
    .wake(wake));

  // Verdict and end of run
  task automatic report_and_stop;
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // Bus cycles; a write leaves the strobe up for a following cycle
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    rd    <= 1'b0;
  endtask : wr_reg

  task automatic bus_idle;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus_idle

  // Single write; returns just past the edge that took it, so results have settled
  task automatic wr1(input logic [3:0] a, input logic [7:0] d);
    wr_reg(a, d);
    bus_idle();
    #1;
  endtask : wr1

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    wr   <= 1'b0;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, msg);
  endtask : rd_chk

  task automatic feed;
    wr_reg(`WDT_A_FEED1, `WDT_FEED1_KEY);
    wr_reg(`WDT_A_FEED2, `WDT_FEED2_KEY);
    bus_idle();
  endtask : feed

  // Bounded wait for irq_out (pick 0) or the reset request (pick 1)
  // Looks once before the first edge too, so a pulse launched by the last edge is seen
  task automatic wait_high(input bit pick, input int limit, output int n);
    for (n = 0; n <= limit; n++)
    begin
      if (n > 0)
        @(posedge clk_sys);
      #1;
      if ((pick ? sys_reset_req : irq_out) === 1'b1)
        return;
    end
    fail_count++;
    $display("MISMATCH at %0t: wait ran out", $time);
    report_and_stop();
  endtask : wait_high

  task automatic settle(input int cycles);
    repeat (cycles) @(posedge clk_sys);
    #1;
  endtask : settle

  // Expected {pending, level, vector}; watchdog is source 6
  function automatic logic [9:0] exp_irq(input logic [6:0] req, input logic [7:0] en, input logic [7:0] pri);
    logic [6:0] act;
    act = req & en[6:0] & {7{en[7]}};
    for (int lvl = 1; lvl >= 0; lvl--)
      for (int i = 0; i < 7; i++)
        if (act[i] && pri[i] == lvl[0])
          return {1'b1, lvl[0], `WDT_VEC_BASE + 8'(`WDT_VEC_STEP * i)};
    return 10'h000;
  endfunction : exp_irq

  // Main sequence
  initial
  begin : main
    int         n;
    int         w;
    int         ex;
    logic [7:0] en;
    logic [7:0] pri;
    logic [9:0] e;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    // Reset values and unmapped places
    rd_chk(`WDT_A_CTRL, 8'he0, "ctrl reset");
    rd_chk(`WDT_A_RELOAD, 8'hff, "reload reset");
    for (int a = 4; a < 16; a++)
      rd_chk(a[3:0], 8'h00, "reg reset");
    wr1(4'hc, 8'hff);
    rd_chk(4'hc, 8'h00, "unmapped write");
    // Power modes outside watchdog mode
    wr1(`WDT_A_PWR, 8'h03);
    settle(2);
    chk({6'h0, power_down, idle_mode}, 8'h02, "pd over idle");
    settle(12);
    chk({6'h0, power_down, idle_mode}, 8'h00, "wake from pd");
    wr1(`WDT_A_PWR, 8'h01);
    settle(2);
    chk({6'h0, power_down, idle_mode}, 8'h01, "idle entry");
    settle(12);
    // Timer mode underflow timing for two taps
    wr1(`WDT_A_IEN, 8'hc0);
    wr1(`WDT_A_IMASK, 8'h01);
    for (int t = 0; t < 2; t++)
    begin
      w = (t == 0) ? 0 : $unsigned($random(seed)) % 3;
      wr1(`WDT_A_RELOAD, w[7:0]);
      wr_reg(`WDT_A_CTRL, {t[2:0], 5'h04});
      rd_chk(`WDT_A_CTRL, {t[2:0], 5'h04}, "ctrl fields");
      wr1(`WDT_A_ISTAT, 8'hff);
      feed();
      wait_high(1'b0, 20000, n);
      ex = (w + 1) * (PER0 << t);
      chk({7'h0, n >= ex - 4 && n <= ex + 4}, 8'h01, "underflow time");
      settle(2);
      chk({6'h0, irq_pending, sys_reset_req}, 8'h02, "timer irq");
      chk(irq_vector, `WDT_VEC_WD, "wd vector");
    end
    // Status mask and clear
    wr1(`WDT_A_IMASK, 8'h00);
    chk({7'h0, irq_out}, 8'h00, "masked");
    wr1(`WDT_A_IMASK, 8'h01);
    chk({7'h0, irq_out}, 8'h01, "unmasked");
    wr1(`WDT_A_ISTAT, 8'h01);
    chk({7'h0, irq_out}, 8'h00, "cleared");
    // Stop the counter, keep the flag
    wr1(`WDT_A_CTRL, 8'h02);
    // Priority and enables, corners first
    for (int k = 0; k < 16; k++)
    begin
      en  = 8'($random(seed));
      pri = 8'($random(seed));
      @(posedge clk_sys);
      other_irq_req <= (k < 3) ? 6'h3f : 6'($random(seed));
      if (k < 3)
      begin
        en  = (k == 2) ? 8'hc0 : 8'hff;
        pri = (k == 0) ? 8'h40 : 8'h00;
      end
      wr_reg(`WDT_A_IEN, en);
      wr_reg(`WDT_A_IPRI, pri);
      bus_idle();
      settle(3);
      e = exp_irq({1'b1, other_irq_req}, en, pri);
      chk({7'h0, irq_pending}, {7'h0, e[9]}, "pending");
      if (e[9])
      begin
        chk({7'h0, irq_level_high}, {7'h0, e[8]}, "level");
        chk(irq_vector, e[7:0], "vector");
      end
    end
    // Core takes the watchdog interrupt
    @(posedge clk_sys);
    other_irq_req <= 6'h00;
    slow          <= 1'($random(seed));
    wr1(`WDT_A_IEN, 8'hc0);
    @(posedge clk_sys);
    serve <= 1'b1;
    settle(12);
    chk({7'h0, irq_pending}, 8'h00, "ack clears");
    rd_chk(`WDT_A_CTRL, 8'h00, "flag cleared");
    serve <= 1'b0;
    // Broken feed
    wr1(`WDT_A_ISTAT, 8'hff);
    wr_reg(`WDT_A_FEED1, `WDT_FEED1_KEY);
    wr_reg(`WDT_A_RELOAD, 8'h05);
    bus_idle();
    wait_high(1'b1, 4, n);
    settle(1);
    chk({7'h0, sys_reset_req}, 8'h00, "pulse length");
    rd_chk(`WDT_A_ISTAT, 8'h02, "feed error");
    // Watchdog mode: power-down refused, underflow resets
    wr1(`WDT_A_RELOAD, 8'h00);
    wr1(`WDT_A_ISTAT, 8'hff);
    // Restart the prescaler first so no stray underflow lands before the checks
    feed();
    wr1(`WDT_A_CTRL, 8'h01);
    wr1(`WDT_A_PWR, 8'h02);
    settle(2);
    chk({7'h0, power_down}, 8'h00, "pd inhibit");
    rd_chk(`WDT_A_ISTAT, 8'h04, "pd blocked");
    feed();
    wait_high(1'b1, 1000, n);
    chk({7'h0, n >= PER0 - 4 && n <= PER0 + 4}, 8'h01, "reset time");
    settle(2);
    chk({6'h0, irq_pending, sys_reset_req}, 8'h00, "no wd irq");
    rd_chk(`WDT_A_CTRL, 8'h03, "flag in wd mode");
    report_and_stop();
  end : main
endmodule : wdt_top_tb
